// ===== rtl/narrow_field_map.v
// maps a 4-bit register field to register index and half select
// assumes the operand size comes from the same clock domain
`include "operand_field_decoder_consts.vh"
module narrow_field_map (
    input wire [3:0] narrow_src_field_i,
    input wire [1:0] size_i,
    output reg [2:0] reg_idx_o,
    output reg upper_word_zero_o,
    output reg low_byte_o
);
    always @* begin
        reg_idx_o = narrow_src_field_i[2:0];
        upper_word_zero_o = 1'b0;
        low_byte_o = 1'b0;
        if (size_i == `OFD_SZ_WORD)
            upper_word_zero_o = narrow_src_field_i[`OFD_HALF_BIT];
        else if (size_i == `OFD_SZ_BYTE)
            low_byte_o = narrow_src_field_i[`OFD_HALF_BIT];
    end
endmodule

// ===== rtl/operand_field_decoder.v
// operand field decoder: register selects and operand field widths
// assumes fetch presents up to four opcode bytes with a valid strobe
//
// Behaviour
// - 3-bit wide field selects one of eight 32-bit registers, 000 first.
// - word operands: codes 0-7 lower word, 8-15 upper extended word.
// - byte operands: codes 0-7 high byte, 8-15 low byte.
// - immediate widths 2, 3, 8, 16 or 32 bits by encoding.
// - displacement widths 8, 16 or 32 bits by variant.
// - absolute address widths 8, 16, 24 or 32 bits by variant.
// - long move store with 32-bit displacement ignores bit 7 of byte four.
`include "operand_field_decoder_consts.vh"
module operand_field_decoder (
    input wire clock_i,
    input wire rst_n_i,
    input wire valid_i,
    input wire [31:0] instr_bytes_i,
    input wire [1:0] size_i,
    input wire [1:0] imm_sel_i,
    input wire [1:0] disp_sel_i,
    input wire [1:0] abs_sel_i,
    output reg valid_o,
    output reg [2:0] wide_idx_o,
    output reg [2:0] narrow_idx_o,
    output reg upper_word_zero_o,
    output reg low_byte_o,
    output reg [2:0] imm_width_o,
    output reg [2:0] disp_width_o,
    output reg [2:0] abs_width_o,
    output reg long_move_instr_o
);
    // byte lanes as fetch presents them, first byte on top
    wire [7:0] b1 = instr_bytes_i[31:24];
    wire [7:0] b2 = instr_bytes_i[23:16];
    wire [7:0] b3 = instr_bytes_i[15:8];
    wire [7:0] b4 = instr_bytes_i[7:0];
    wire [3:0] narrow_src_field = b2[7:4];
    wire [2:0] n_idx;
    wire n_upper;
    wire n_low;
    wire long_move_hit;
    wire [2:0] wide_sel;

    // next values, one per output flop
    reg valid_d;
    reg [2:0] wide_idx_d;
    reg [2:0] narrow_idx_d;
    reg upper_word_zero_d;
    reg low_byte_d;
    reg [2:0] imm_width_d;
    reg [2:0] disp_width_d;
    reg [2:0] abs_width_d;
    reg long_move_instr_d;

    // one shared split for word and byte sizes
    narrow_field_map u_map (
        .narrow_src_field_i(narrow_src_field),
        .size_i(size_i),
        .reg_idx_o(n_idx),
        .upper_word_zero_o(n_upper),
        .low_byte_o(n_low)
    );

    // byte four is never matched, so its top bit may take either value
    function long_move_match;
        input [7:0] first_byte;
        input [7:0] second_byte;
        input [7:0] third_byte;
        begin
            long_move_match = (first_byte == 8'h01)
                && (second_byte == 8'h00)
                && (third_byte == 8'h78);
        end
    endfunction

    assign long_move_hit = long_move_match(b1, b2, b3);
    assign wide_sel = long_move_hit ? b4[6:4] : b2[2:0];

    // short immediates: the next nibble tells the two-bit form from the three-bit one
    function [2:0] imm_w;
        input [1:0] s;
        input [3:0] hi;
        begin
            case (s)
                2'h0: imm_w = `OFD_WD_8;
                2'h1: imm_w = `OFD_WD_16;
                2'h2: imm_w = `OFD_WD_32;
                default: imm_w = (hi == 4'h0) ? `OFD_WD_2 : `OFD_WD_3;
            endcase
        end
    endfunction

    // variant three carries no displacement at all
    function [2:0] disp_w;
        input [1:0] s;
        begin
            case (s)
                2'h0: disp_w = `OFD_WD_8;
                2'h1: disp_w = `OFD_WD_16;
                2'h2: disp_w = `OFD_WD_32;
                default: disp_w = `OFD_WD_NONE;
            endcase
        end
    endfunction

    // width selects come from fetch, not from an opcode lookup
    function [2:0] abs_w;
        input [1:0] s;
        begin
            case (s)
                2'h0: abs_w = `OFD_WD_8;
                2'h1: abs_w = `OFD_WD_16;
                2'h2: abs_w = `OFD_WD_24;
                default: abs_w = `OFD_WD_32;
            endcase
        end
    endfunction

    // fields only move on a taken strobe; idle cycles keep the last decode
    always @* begin
        valid_d = valid_i;
        wide_idx_d = wide_idx_o;
        narrow_idx_d = narrow_idx_o;
        upper_word_zero_d = upper_word_zero_o;
        low_byte_d = low_byte_o;
        imm_width_d = imm_width_o;
        disp_width_d = disp_width_o;
        abs_width_d = abs_width_o;
        long_move_instr_d = long_move_instr_o;
        if (valid_i) begin
            wide_idx_d = wide_sel;
            narrow_idx_d = n_idx;
            upper_word_zero_d = n_upper;
            low_byte_d = n_low;
            imm_width_d = imm_w(imm_sel_i, b2[7:4]);
            if (long_move_hit) begin
                disp_width_d = `OFD_WD_32;
            end else begin
                disp_width_d = disp_w(disp_sel_i);
            end
            abs_width_d = abs_w(abs_sel_i);
            long_move_instr_d = long_move_hit;
        end
    end

    // registered so every output comes from a flop; one cycle of latency
    // traded for clean timing into the datapath
    always @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            valid_o <= 1'b0;
        end else begin
            valid_o <= valid_d;
        end
    end

    always @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            wide_idx_o <= `OFD_RESET_IDX;
        end else begin
            wide_idx_o <= wide_idx_d;
        end
    end

    always @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            narrow_idx_o <= `OFD_RESET_IDX;
        end else begin
            narrow_idx_o <= narrow_idx_d;
        end
    end

    always @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            upper_word_zero_o <= 1'b0;
        end else begin
            upper_word_zero_o <= upper_word_zero_d;
        end
    end

    always @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            low_byte_o <= 1'b0;
        end else begin
            low_byte_o <= low_byte_d;
        end
    end

    always @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            imm_width_o <= `OFD_RESET_WD;
        end else begin
            imm_width_o <= imm_width_d;
        end
    end

    always @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            disp_width_o <= `OFD_RESET_WD;
        end else begin
            disp_width_o <= disp_width_d;
        end
    end

    always @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            abs_width_o <= `OFD_RESET_WD;
        end else begin
            abs_width_o <= abs_width_d;
        end
    end

    always @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            long_move_instr_o <= 1'b0;
        end else begin
            long_move_instr_o <= long_move_instr_d;
        end
    end
endmodule

// ===== rtl/operand_field_decoder_consts.vh
// constants for the operand field decoder: field positions, widths, codes
// assumes inclusion by the decoder files only
`ifndef OPERAND_FIELD_DECODER_CONSTS_VH
`define OPERAND_FIELD_DECODER_CONSTS_VH
`define OFD_WIDE_SEL_W 3
`define OFD_NARROW_SEL_W 4
`define OFD_HALF_BIT 3
`define OFD_SZ_BYTE 2'h0
`define OFD_SZ_WORD 2'h1
`define OFD_SZ_LONG 2'h2
`define OFD_WD_NONE 3'h0
`define OFD_WD_2 3'h1
`define OFD_WD_3 3'h2
`define OFD_WD_8 3'h3
`define OFD_WD_16 3'h4
`define OFD_WD_24 3'h5
`define OFD_WD_32 3'h6
`define OFD_DONT_CARE_BIT 7
`define OFD_RESET_IDX 3'h0
`define OFD_RESET_WD 3'h0
`endif

// ===== testbench/op_fetch_model.sv
// fetch side model: opcode bytes with a valid strobe
// assumes the bench drives go and word at the clock edge
module op_fetch_model(input wire clock_i, input wire go_i, input wire [31:0] word_i,
    output reg valid_o = 0, output reg [31:0] bytes_o = 0);
    timeunit 1ns;
    timeprecision 1ns;
    // idle bytes flip so stale bytes never look held
    always @(posedge clock_i) begin
        valid_o <= go_i;
        bytes_o <= go_i ? word_i : ~bytes_o;
    end
endmodule

// ===== testbench/operand_field_decoder_assertions.sv
// assertions on the decoder ports
// assumes a bind from the bench top
module operand_field_decoder_checker(input wire clock_i, rst_n_i, valid_i,
    input wire [31:0] instr_bytes_i, input wire [1:0] size_i, imm_sel_i, disp_sel_i, abs_sel_i,
    input wire valid_o, upper_word_zero_o, low_byte_o, long_move_instr_o,
    input wire [2:0] wide_idx_o, narrow_idx_o, imm_width_o, disp_width_o, abs_width_o);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge clock_i); endclocking
    default disable iff (!rst_n_i);
    wire lm = valid_i && instr_bytes_i[31:8] == 24'h010078;
    wire [7:0] b2 = instr_bytes_i[23:16];
    a_valid_next: assert property (valid_o == $past(valid_i)) else $error("valid");
    a_wide_sel: assert property (valid_i && !lm |=>
        wide_idx_o == $past(b2[2:0])) else $error("wide");
    a_long_move: assert property (lm |=> long_move_instr_o && disp_width_o == 3'h6 &&
        wide_idx_o == $past(instr_bytes_i[6:4])) else $error("long");
    a_narrow_sel: assert property (valid_i |=>
        narrow_idx_o == $past(b2[6:4])) else $error("narrow");
    a_word_half: assert property (valid_i && size_i == 2'h1 |=>
        upper_word_zero_o == $past(b2[7]) && !low_byte_o) else $error("word");
    a_byte_half: assert property (valid_i && size_i == 2'h0 |=>
        low_byte_o == $past(b2[7]) && !upper_word_zero_o) else $error("byte");
    a_abs_width: assert property (valid_i |=>
        abs_width_o == $past(abs_sel_i) + 3'h3) else $error("abs");
    a_imm_short: assert property (valid_i && imm_sel_i == 2'h3 |=>
        imm_width_o == ($past(b2[7:4]) == 4'h0 ? 3'h1 : 3'h2)) else $error("imm");
    a_disp_width: assert property (valid_i && !lm |=> disp_width_o ==
        ($past(disp_sel_i) == 2'h3 ? 3'h0 : $past(disp_sel_i) == 2'h2 ? 3'h6
        : {1'b0, $past(disp_sel_i)} + 3'h3)) else $error("disp");
    a_hold_idle: assert property (!valid_i |=> $stable(wide_idx_o) && $stable(narrow_idx_o)
        && $stable(imm_width_o) && $stable(disp_width_o) && $stable(abs_width_o))
        else $error("hold");
    cover property (lm);
    cover property (valid_i && size_i == 2'h1);
    cover property (valid_i && imm_sel_i == 2'h3);
    cover property (lm && instr_bytes_i[7]);
endmodule

// ===== testbench/operand_field_decoder_bench.sv
// bench for the operand field decoder
// assumes model and checker compile first
`define chk(a, b) begin num_checks++; if ((a) !== (b)) begin bad_count++; \
    $display("unexpected %0t %h %h", $time, a, b); end end
module operand_field_decoder_bench;
timeunit 1ns;
timeprecision 1ns;
logic clock_i = 0, rst_n_i = 0, go = 0;
logic [31:0] word = 0;
logic [1:0] size = 0, imm = 0, disp = 0, ab = 0;
wire valid_i, valid_o, upper_word_zero_o, low_byte_o, long_move_instr_o;
wire [31:0] instr_bytes_i;
wire [2:0] wide_idx_o, narrow_idx_o, imm_width_o, disp_width_o, abs_width_o;
int bad_count = 0, num_checks = 0;
initial forever #20 clock_i = ~clock_i;
op_fetch_model fm(.clock_i, .go_i(go), .word_i(word), .valid_o(valid_i), .bytes_o(instr_bytes_i));
operand_field_decoder dut(.clock_i, .rst_n_i, .valid_i, .instr_bytes_i, .size_i(size),
    .imm_sel_i(imm), .disp_sel_i(disp), .abs_sel_i(ab), .valid_o, .wide_idx_o, .narrow_idx_o,
    .upper_word_zero_o, .low_byte_o, .imm_width_o, .disp_width_o, .abs_width_o,
    .long_move_instr_o);
task send(input [31:0] w, input [1:0] s, i, d, a);
    @(posedge clock_i) begin word <= w; size <= s; imm <= i; disp <= d; ab <= a; go <= 1; end
    @(posedge clock_i) go <= 0;
    @(negedge clock_i) `chk(valid_o, 1'b0)
    @(negedge clock_i) `chk(valid_o, 1'b1)
endtask
task t_regs;
    for (int c = 0; c < 32; c++) begin
        send({8'h0c, c[3:0], c[3:0], 16'h0}, {1'b0, c[4]}, 0, 0, 0);
        `chk(wide_idx_o, c[2:0])
        `chk({narrow_idx_o, c[4] ? upper_word_zero_o : low_byte_o}, {c[2:0], c[3]})
        `chk(c[4] ? low_byte_o : upper_word_zero_o, 1'b0)
    end
endtask
task t_widths;
    for (int k = 0; k < 8; k++) begin
        send({8'h79, 3'h0, k[2], 20'h0}, 0, k[1:0], k[1:0], k[1:0]);
        `chk(imm_width_o, k[1:0] == 3 ? 3'h1 + k[2] : k[1:0] == 2 ? 3'h6 : k[1:0] + 3'h3)
        `chk(disp_width_o, k[1:0] == 3 ? 3'h0 : k[1:0] == 2 ? 3'h6 : k[1:0] + 3'h3)
        `chk(abs_width_o, k[1:0] + 3'h3)
    end
endtask
task t_long;
    for (int b = 0; b < 3; b++) begin
        send({8'h01, 8'h00, 8'h78 + b[1], b[0], 7'h60}, 2, 0, 0, 0);
        `chk({long_move_instr_o, wide_idx_o, disp_width_o}, b[1] ? 7'h03 : 7'h76)
    end
endtask
task stop_test;
    if (bad_count == 0 && num_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
endtask
initial begin
    repeat (5) @(posedge clock_i);
    rst_n_i <= 1;
    t_regs;
    t_widths;
    t_long;
    stop_test;
end
initial begin
    #20000;
    bad_count++;
    stop_test;
end
endmodule
bind operand_field_decoder operand_field_decoder_checker chk_u(.clock_i(clock_i),
    .rst_n_i(rst_n_i), .valid_i(valid_i), .instr_bytes_i(instr_bytes_i),
    .size_i(size_i), .imm_sel_i(imm_sel_i), .disp_sel_i(disp_sel_i),
    .abs_sel_i(abs_sel_i), .valid_o(valid_o), .upper_word_zero_o(upper_word_zero_o),
    .low_byte_o(low_byte_o), .long_move_instr_o(long_move_instr_o),
    .wide_idx_o(wide_idx_o), .narrow_idx_o(narrow_idx_o), .imm_width_o(imm_width_o),
    .disp_width_o(disp_width_o), .abs_width_o(abs_width_o));
